/* rtl/ntfsm_pkg.sv */
// Constants, state encoding and fault-set decoding for the network-side fault state machine.
package ntfsm_pkg;

  // Bit positions of the four fault conditions inside a fault set.
  localparam int unsigned FAULT_ACCESS_UPSTREAM_BIT      = 0;
  localparam int unsigned FAULT_INTERFACE_DOWNSTREAM_BIT = 1;
  localparam int unsigned FAULT_ACCESS_DOWNSTREAM_BIT    = 2;
  localparam int unsigned FAULT_INTERFACE_UPSTREAM_BIT   = 3;
  localparam int unsigned FAULT_COUNT                    = 4;

  // Primitive index of the power indications inside the error and clear vectors.
  localparam int unsigned POWER_PRIM_IDX = 0;
  localparam int unsigned PRIM_COUNT     = 5;

  localparam logic [3:0] FAULT_NONE         = 4'h0;
  localparam logic [3:0] FAULT_IF_DOWN_MASK = 4'h2;

  // Gray-coded along power off, power on, operational and the fault states.
  typedef enum logic [3:0] {
    ST_G0  = 4'h0,
    ST_G13 = 4'h1,
    ST_G1  = 4'h3,
    ST_G2  = 4'h2,
    ST_G3  = 4'h6,
    ST_G4  = 4'h7,
    ST_G5  = 4'h5,
    ST_G6  = 4'h4,
    ST_G7  = 4'hc,
    ST_G8  = 4'hd,
    ST_G9  = 4'hf,
    ST_G10 = 4'he,
    ST_G11 = 4'ha,
    ST_G12 = 4'hb
  } ntfsm_state_t;

  localparam ntfsm_state_t RESET_STATE = ST_G0;

  typedef enum logic [2:0] {
    EV_NONE       = 3'h0,
    EV_POWER_LOSS = 3'h1,
    EV_POWER_BACK = 3'h3,
    EV_NORMAL     = 3'h2,
    EV_APPEAR     = 3'h6,
    EV_CLEAR      = 3'h7
  } ntfsm_event_t;

  // Fault set of a state; merged states report the interface downstream fault as present.
  function automatic logic [3:0] fault_set_of(input ntfsm_state_t st);
    case (st)
      ST_G2:   fault_set_of = 4'h1;
      ST_G3:   fault_set_of = 4'h2;
      ST_G4:   fault_set_of = 4'h4;
      ST_G5:   fault_set_of = 4'ha;
      ST_G6:   fault_set_of = 4'h3;
      ST_G7:   fault_set_of = 4'h5;
      ST_G8:   fault_set_of = 4'hb;
      ST_G9:   fault_set_of = 4'h6;
      ST_G10:  fault_set_of = 4'he;
      ST_G11:  fault_set_of = 4'h7;
      ST_G12:  fault_set_of = 4'hf;
      default: fault_set_of = 4'h0;
    endcase
  endfunction

  // State that holds a fault set; an upstream interface fault folds in the downstream one.
  function automatic ntfsm_state_t state_of_set(input logic [3:0] set);
    logic [3:0] s;
    s = set;
    if (set[FAULT_INTERFACE_UPSTREAM_BIT]) begin
      s = set | FAULT_IF_DOWN_MASK;
    end
    case (s)
      4'h1:    state_of_set = ST_G2;
      4'h2:    state_of_set = ST_G3;
      4'h4:    state_of_set = ST_G4;
      4'ha:    state_of_set = ST_G5;
      4'h3:    state_of_set = ST_G6;
      4'h5:    state_of_set = ST_G7;
      4'hb:    state_of_set = ST_G8;
      4'h6:    state_of_set = ST_G9;
      4'he:    state_of_set = ST_G10;
      4'h7:    state_of_set = ST_G11;
      4'hf:    state_of_set = ST_G12;
      default: state_of_set = ST_G1;
    endcase
  endfunction

endpackage

/* rtl/ntfsm_if.sv */
// Internal carrier between event selection, state core and maintenance signal selection.
`timescale 1ns/1ps
interface ntfsm_if;
  ntfsm_pkg::ntfsm_event_t ev_kind;
  logic [1:0]              ev_idx;
  ntfsm_pkg::ntfsm_state_t state;

  modport sel   (output ev_kind, output ev_idx);
  modport core  (input ev_kind, input ev_idx, output state);
  modport maint (input state);
endinterface

/* rtl/ntfsm_evsel.sv */
// Picks the single event that the state core acts on in this cycle.
`timescale 1ns/1ps
module ntfsm_evsel (
  input  wire logic       power_loss_i,
  input  wire logic       power_back_i,
  input  wire logic       normal_cells_i,
  input  wire logic [3:0] fault_appear_i,
  input  wire logic [3:0] fault_clear_i,
  ntfsm_if.sel            ev
);

  // Power events outrank cells and faults; lower fault index wins a tie.
  always_comb begin
    ev.ev_kind = ntfsm_pkg::EV_NONE;
    ev.ev_idx  = 2'h0;
    for (int i = ntfsm_pkg::FAULT_COUNT - 1; i >= 0; i--) begin
      if (fault_clear_i[i]) begin
        ev.ev_kind = ntfsm_pkg::EV_CLEAR;
        ev.ev_idx  = 2'(i);
      end
    end
    for (int i = ntfsm_pkg::FAULT_COUNT - 1; i >= 0; i--) begin
      if (fault_appear_i[i]) begin
        ev.ev_kind = ntfsm_pkg::EV_APPEAR;
        ev.ev_idx  = 2'(i);
      end
    end
    if (normal_cells_i) begin
      ev.ev_kind = ntfsm_pkg::EV_NORMAL;
    end
    if (power_back_i) begin
      ev.ev_kind = ntfsm_pkg::EV_POWER_BACK;
    end
    if (power_loss_i) begin
      ev.ev_kind = ntfsm_pkg::EV_POWER_LOSS;
    end
  end

endmodule

/* rtl/ntfsm_maint.sv */
// Chooses the maintenance signal sent toward the interface from the current state.
`timescale 1ns/1ps
module ntfsm_maint (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ntfsm_if.maint    st,
  output logic      no_signal_o,
  output logic      normal_o,
  output logic      p_ais_o,
  output logic      s_rdi_o,
  output logic      p_rdi_o
);

  logic [3:0] fs;
  logic       powered;
  logic       no_signal_d, normal_d, p_ais_d, s_rdi_d, p_rdi_d;
  logic       no_signal_q, normal_q, p_ais_q, s_rdi_q, p_rdi_q;
  logic       fa_up, fa_dn, fi_up;

  always_comb begin
    fs      = ntfsm_pkg::fault_set_of(st.state);
    fa_up   = fs[ntfsm_pkg::FAULT_ACCESS_UPSTREAM_BIT];
    fa_dn   = fs[ntfsm_pkg::FAULT_ACCESS_DOWNSTREAM_BIT];
    fi_up   = fs[ntfsm_pkg::FAULT_INTERFACE_UPSTREAM_BIT];
    powered = (st.state != ntfsm_pkg::ST_G0) && (st.state != ntfsm_pkg::ST_G13);
    no_signal_d = !powered;
    p_ais_d     = powered && fa_dn;
    s_rdi_d     = powered && fi_up;
    p_rdi_d     = powered && ((fi_up && !fa_dn) || (fa_up && (!fa_dn || fi_up)));
    normal_d    = powered && !p_ais_d && !s_rdi_d && !p_rdi_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      no_signal_q <= 1'b1;
      normal_q    <= 1'b0;
      p_ais_q     <= 1'b0;
      s_rdi_q     <= 1'b0;
      p_rdi_q     <= 1'b0;
    end else begin
      no_signal_q <= no_signal_d;
      normal_q    <= normal_d;
      p_ais_q     <= p_ais_d;
      s_rdi_q     <= s_rdi_d;
      p_rdi_q     <= p_rdi_d;
    end
  end

  assign no_signal_o = no_signal_q;
  assign normal_o    = normal_q;
  assign p_ais_o     = p_ais_q;
  assign s_rdi_o     = s_rdi_q;
  assign p_rdi_o     = p_rdi_q;

endmodule

/* rtl/ntfsm_top.sv */
// Network-side physical layer fault state machine with primitive and maintenance outputs.
//
// Notes on behaviour
// - Fourteen states; upstream interface fault merges downstream.
// - No signal in power off and power on; RDI for access upstream.
// - AIS for access downstream; RDI for interface upstream.
// - Power loss goes to power off, error zero.
// - Power return in power off gives power on.
// - Normal cells return faulted states to operational.
// - Access upstream fault appears: error one, add.
// - Interface downstream fault appears: error two, add.
// - Access downstream fault appears: error three, add.
// - Interface downstream fault hides the others.
// - Access downstream fault hides access upstream.
// - Interface upstream fault appears: error four, add.
// - Fault disappears: clear indication, drop fault.
`timescale 1ns/1ps
module ntfsm_top (
  input  wire logic       REF_CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       POWER_LOSS_I,
  input  wire logic       POWER_RETURN_I,
  input  wire logic       NORMAL_CELLS_I,
  input  wire logic       FAULT_ACCESS_UPSTREAM_SET_I,
  input  wire logic       FAULT_INTERFACE_DOWNSTREAM_SET_I,
  input  wire logic       FAULT_ACCESS_DOWNSTREAM_SET_I,
  input  wire logic       FAULT_INTERFACE_UPSTREAM_SET_I,
  input  wire logic       FAULT_ACCESS_UPSTREAM_CLR_I,
  input  wire logic       FAULT_INTERFACE_DOWNSTREAM_CLR_I,
  input  wire logic       FAULT_ACCESS_DOWNSTREAM_CLR_I,
  input  wire logic       FAULT_INTERFACE_UPSTREAM_CLR_I,
  output logic [3:0]      STATE_O,
  output logic            PH_AI_O,
  output logic            PH_DI_O,
  output logic            MPH_AI_O,
  output logic [4:0]      MPH_EI_O,
  output logic [4:0]      MPH_CI_O,
  output logic            TX_NO_SIGNAL_O,
  output logic            TX_NORMAL_O,
  output logic            TX_P_AIS_O,
  output logic            TX_S_RDI_O,
  output logic            TX_P_RDI_O
);

  ntfsm_if bus ();

  ntfsm_pkg::ntfsm_state_t state_d, state_q;
  logic                    ph_ai_d, ph_ai_q;
  logic                    ph_di_d, ph_di_q;
  logic                    mph_ai_d, mph_ai_q;
  logic [4:0]              mph_ei_d, mph_ei_q;
  logic [4:0]              mph_ci_d, mph_ci_q;
  logic [3:0]              cur_set;
  logic [3:0]              new_set;
  logic [3:0]              ev_bit;
  logic                    in_fault;

  ntfsm_evsel u_evsel (
    .power_loss_i   (POWER_LOSS_I),
    .power_back_i   (POWER_RETURN_I),
    .normal_cells_i (NORMAL_CELLS_I),
    .fault_appear_i ({FAULT_INTERFACE_UPSTREAM_SET_I, FAULT_ACCESS_DOWNSTREAM_SET_I,
                      FAULT_INTERFACE_DOWNSTREAM_SET_I, FAULT_ACCESS_UPSTREAM_SET_I}),
    .fault_clear_i  ({FAULT_INTERFACE_UPSTREAM_CLR_I, FAULT_ACCESS_DOWNSTREAM_CLR_I,
                      FAULT_INTERFACE_DOWNSTREAM_CLR_I, FAULT_ACCESS_UPSTREAM_CLR_I}),
    .ev             (bus.sel)
  );

  ntfsm_maint u_maint (
    .clk_i       (REF_CLK_I),
    .rst_i       (RESET_I),
    .st          (bus.maint),
    .no_signal_o (TX_NO_SIGNAL_O),
    .normal_o    (TX_NORMAL_O),
    .p_ais_o     (TX_P_AIS_O),
    .s_rdi_o     (TX_S_RDI_O),
    .p_rdi_o     (TX_P_RDI_O)
  );

  assign bus.state = state_q;

  // Faults are tracked as a set so that every appear and clear row follows from one rule.
  // Detections hidden behind a masking fault simply never arrive as events, so the set
  // logic keeps whatever it was last told instead of guessing at masked faults.
  always_comb begin
    state_d  = state_q;
    ph_ai_d  = 1'b0;
    ph_di_d  = 1'b0;
    mph_ai_d = 1'b0;
    mph_ei_d = '0;
    mph_ci_d = '0;
    cur_set  = ntfsm_pkg::fault_set_of(state_q);
    ev_bit   = 4'h1 << bus.ev_idx;
    new_set  = cur_set;
    in_fault = (state_q != ntfsm_pkg::ST_G0) && (state_q != ntfsm_pkg::ST_G1) &&
               (state_q != ntfsm_pkg::ST_G13);
    case (bus.ev_kind)
      ntfsm_pkg::EV_POWER_LOSS: begin
        if (state_q != ntfsm_pkg::ST_G0) begin
          mph_ei_d[ntfsm_pkg::POWER_PRIM_IDX] = 1'b1;
          ph_di_d = (state_q == ntfsm_pkg::ST_G1);
          state_d = ntfsm_pkg::ST_G0;
        end
      end
      ntfsm_pkg::EV_POWER_BACK: begin
        if (state_q == ntfsm_pkg::ST_G0) begin
          mph_ci_d[ntfsm_pkg::POWER_PRIM_IDX] = 1'b1;
          state_d = ntfsm_pkg::ST_G13;
        end
      end
      ntfsm_pkg::EV_NORMAL: begin
        if (in_fault || state_q == ntfsm_pkg::ST_G13) begin
          ph_ai_d  = 1'b1;
          mph_ai_d = 1'b1;
          state_d  = ntfsm_pkg::ST_G1;
        end
      end
      ntfsm_pkg::EV_APPEAR: begin
        // A fault already in the set, or hidden by a merge, changes nothing.
        if (state_q != ntfsm_pkg::ST_G0 && (cur_set & ev_bit) == ntfsm_pkg::FAULT_NONE) begin
          new_set = cur_set | ev_bit;
          mph_ei_d[bus.ev_idx + 3'h1] = 1'b1;
          ph_di_d = (state_q == ntfsm_pkg::ST_G1);
          state_d = ntfsm_pkg::state_of_set(new_set);
        end
      end
      ntfsm_pkg::EV_CLEAR: begin
        // The downstream interface fault cannot clear while merged under the upstream one.
        if (in_fault && (cur_set & ev_bit) != ntfsm_pkg::FAULT_NONE &&
            !(bus.ev_idx == 2'(ntfsm_pkg::FAULT_INTERFACE_DOWNSTREAM_BIT) &&
              cur_set[ntfsm_pkg::FAULT_INTERFACE_UPSTREAM_BIT])) begin
          new_set = cur_set & ~ev_bit;
          if (bus.ev_idx == 2'(ntfsm_pkg::FAULT_INTERFACE_UPSTREAM_BIT)) begin
            new_set = new_set | ntfsm_pkg::FAULT_IF_DOWN_MASK;
          end
          mph_ci_d[bus.ev_idx + 3'h1] = 1'b1;
          state_d = ntfsm_pkg::state_of_set(new_set);
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      state_q  <= ntfsm_pkg::RESET_STATE;
      ph_ai_q  <= 1'b0;
      ph_di_q  <= 1'b0;
      mph_ai_q <= 1'b0;
      mph_ei_q <= '0;
      mph_ci_q <= '0;
    end else begin
      state_q  <= state_d;
      ph_ai_q  <= ph_ai_d;
      ph_di_q  <= ph_di_d;
      mph_ai_q <= mph_ai_d;
      mph_ei_q <= mph_ei_d;
      mph_ci_q <= mph_ci_d;
    end
  end

  assign STATE_O  = state_q;
  assign PH_AI_O  = ph_ai_q;
  assign PH_DI_O  = ph_di_q;
  assign MPH_AI_O = mph_ai_q;
  assign MPH_EI_O = mph_ei_q;
  assign MPH_CI_O = mph_ci_q;

endmodule

/* verification/ntfsm_monitor.sv */
// Concurrent checks on the ports of the network-side fault state machine.
`timescale 1ns/1ps
module ntfsm_monitor (
  input wire logic       REF_CLK_I,
  input wire logic       RESET_I,
  input wire logic       POWER_LOSS_I,
  input wire logic       POWER_RETURN_I,
  input wire logic       NORMAL_CELLS_I,
  input wire logic       FAULT_ACCESS_UPSTREAM_SET_I,
  input wire logic [3:0] STATE_O,
  input wire logic       PH_AI_O,
  input wire logic       PH_DI_O,
  input wire logic       MPH_AI_O,
  input wire logic [4:0] MPH_EI_O,
  input wire logic [4:0] MPH_CI_O,
  input wire logic       TX_NO_SIGNAL_O,
  input wire logic       TX_P_AIS_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  logic pw;
  // Power events outrank every other event in the same cycle.
  assign pw = POWER_LOSS_I | POWER_RETURN_I;
  a_loss_to_off: assert property (POWER_LOSS_I && STATE_O != 4'h0
    |=> STATE_O == 4'h0 && MPH_EI_O == 5'h01) else $error("power loss not taken");
  a_loss_deact: assert property (POWER_LOSS_I
    |=> PH_DI_O == ($past(STATE_O) == 4'h3)) else $error("deactivation wrong on loss");
  a_return_on: assert property (!POWER_LOSS_I && POWER_RETURN_I && STATE_O == 4'h0
    |=> STATE_O == 4'h1 && MPH_CI_O == 5'h01) else $error("power return not taken");
  a_return_held: assert property (!POWER_LOSS_I && POWER_RETURN_I && STATE_O != 4'h0
    |=> $stable(STATE_O) && MPH_CI_O == 5'h00) else $error("refused return acted");
  a_normal_joins: assert property (!pw && NORMAL_CELLS_I && STATE_O != 4'h0
    && STATE_O != 4'h3
    |=> STATE_O == 4'h3 && PH_AI_O && MPH_AI_O) else $error("normal cells not taken");
  a_ai_paired: assert property (PH_AI_O == MPH_AI_O)
    else $error("activation pair split");
  a_acc_up_op: assert property (!pw && !NORMAL_CELLS_I && FAULT_ACCESS_UPSTREAM_SET_I
    && STATE_O == 4'h3 |=> STATE_O == 4'h2 && PH_DI_O && MPH_EI_O == 5'h02)
    else $error("access upstream fault not taken");
  a_tx_silent: assert property (1'b1 |=> TX_NO_SIGNAL_O == ($past(STATE_O) < 4'h2))
    else $error("no-signal output wrong");
  a_tx_ais: assert property (1'b1 |=> TX_P_AIS_O ==
    ($past(STATE_O) inside {4'h7, 4'hc, 4'hf, 4'he, 4'ha, 4'hb})) else $error("AIS wrong");
  c_all_faults: cover property (STATE_O == 4'hb);
  c_merged: cover property (STATE_O == 4'h5);
  c_clear_up: cover property (MPH_CI_O[4]);
endmodule

/* verification/ntfsm_user_model.sv */
// Behavioural user-side terminal: sends normal cells or raises and drops its RDI pair.
`timescale 1ns/1ps
module ntfsm_user_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] req_i,
  input  wire logic [3:0] delay_i,
  output logic            normal_o,
  output logic            rdi_on_o,
  output logic            rdi_off_o
);
  logic [1:0] pend = 2'h0;
  logic [3:0] cnt  = 4'h0;
  initial begin
    {normal_o, rdi_on_o, rdi_off_o} = 3'b000;
  end
  // Each indication is one cycle long; a slow answer waits delay_i cycles first.
  always @(negedge clk_i) begin
    {normal_o, rdi_on_o, rdi_off_o} <= 3'b000;
    if (pend == 2'h0) begin
      pend <= req_i;
      cnt  <= delay_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      normal_o  <= (pend == 2'h1);
      rdi_on_o  <= (pend == 2'h2);
      rdi_off_o <= (pend == 2'h3);
      pend      <= 2'h0;
    end
  end
endmodule

/* verification/tb_ntfsm_top.sv */
// Directed bench for the network-side fault state machine with a user-side model.
`timescale 1ns/1ps
module tb_ntfsm_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [9:0] ev  = 10'h000;
  logic [1:0] req = 2'h0;
  logic [3:0] dly = 4'h0;
  logic       nc, r_on, r_off, ai, di, mai;
  logic [3:0] st;
  logic [4:0] ei, ci;
  wire  [4:0] tx;
  int         errors = 0;
  int         checks_done = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  ntfsm_user_model i_user (.clk_i(clk), .req_i(req), .delay_i(dly), .normal_o(nc),
    .rdi_on_o(r_on), .rdi_off_o(r_off));
  // The far side alone raises and drops the interface downstream fault.
  ntfsm_top i_dut (.REF_CLK_I(clk), .RESET_I(rst), .POWER_LOSS_I(ev[9]),
    .POWER_RETURN_I(ev[8]), .NORMAL_CELLS_I(nc), .FAULT_ACCESS_UPSTREAM_SET_I(ev[4]),
    .FAULT_INTERFACE_DOWNSTREAM_SET_I(r_on), .FAULT_ACCESS_DOWNSTREAM_SET_I(ev[6]),
    .FAULT_INTERFACE_UPSTREAM_SET_I(ev[7]), .FAULT_ACCESS_UPSTREAM_CLR_I(ev[0]),
    .FAULT_INTERFACE_DOWNSTREAM_CLR_I(r_off), .FAULT_ACCESS_DOWNSTREAM_CLR_I(ev[2]),
    .FAULT_INTERFACE_UPSTREAM_CLR_I(ev[3]), .STATE_O(st), .PH_AI_O(ai), .PH_DI_O(di),
    .MPH_AI_O(mai), .MPH_EI_O(ei), .MPH_CI_O(ci), .TX_NO_SIGNAL_O(tx[4]),
    .TX_NORMAL_O(tx[3]), .TX_P_AIS_O(tx[2]), .TX_S_RDI_O(tx[1]), .TX_P_RDI_O(tx[0]));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic look(input logic [3:0] s, input logic [12:0] p);
    check({st, ai, di, mai, ei, ci}, {s, p});
  endtask
  task automatic tx_is(input logic [4:0] e);
    @(negedge clk);
    check({12'h000, tx}, {12'h000, e});
  endtask
  task automatic step(input logic [9:0] v, input logic [3:0] s, input logic [12:0] p);
    @(negedge clk);
    ev <= v;
    @(negedge clk);
    ev <= 10'h000;
    look(s, p);
  endtask
  task automatic usr(input logic [1:0] r, input logic [3:0] d, input logic [3:0] s,
                     input logic [12:0] p);
    int n;
    n = 0;
    @(negedge clk);
    req <= r;
    dly <= d;
    @(negedge clk);
    req <= 2'h0;
    do begin
      @(posedge clk);
      n++;
    end while (!(nc | r_on | r_off) && n < 20);
    if (!(nc | r_on | r_off)) begin
      errors++;
      end_of_test();
    end else begin
      @(negedge clk);
      look(s, p);
    end
  endtask
  task automatic t_power();
    look(4'h0, 13'h000);
    tx_is(5'h10);
    step(10'h100, 4'h1, 13'h001);
    step(10'h100, 4'h1, 13'h000);
    tx_is(5'h10);
    step(10'h200, 4'h0, 13'h020);
    step(10'h200, 4'h0, 13'h000);
  endtask
  task automatic t_faults();
    step(10'h100, 4'h1, 13'h001);
    step(10'h010, 4'h2, 13'h040);
    usr(2'h1, 4'h0, 4'h3, 13'h1400);
    tx_is(5'h08);
    step(10'h010, 4'h2, 13'h840);
    tx_is(5'h01);
    step(10'h040, 4'hc, 13'h100);
    tx_is(5'h04);
    step(10'h010, 4'hc, 13'h000);
    usr(2'h2, 4'h3, 4'ha, 13'h080);
    step(10'h040, 4'ha, 13'h000);
    step(10'h080, 4'hb, 13'h200);
    tx_is(5'h07);
    step(10'h008, 4'ha, 13'h010);
    step(10'h004, 4'h4, 13'h008);
    step(10'h001, 4'h6, 13'h002);
    tx_is(5'h08);
    usr(2'h3, 4'h0, 4'h3, 13'h004);
  endtask
  task automatic t_merge();
    step(10'h080, 4'h5, 13'ha00);
    usr(2'h2, 4'h0, 4'h5, 13'h000);
    tx_is(5'h03);
    step(10'h040, 4'he, 13'h100);
    tx_is(5'h06);
    usr(2'h1, 4'h1, 4'h3, 13'h1400);
    step(10'h200, 4'h0, 13'h820);
  endtask
  // Refused events in power off, priority of loss over return, and leaving a merged state.
  task automatic t_recover();
    step(10'h010, 4'h0, 13'h000);
    step(10'h300, 4'h0, 13'h000);
    step(10'h100, 4'h1, 13'h001);
    usr(2'h1, 4'h0, 4'h3, 13'h1400);
    step(10'h080, 4'h5, 13'ha00);
    usr(2'h3, 4'h0, 4'h5, 13'h000);
    step(10'h008, 4'h6, 13'h010);
    tx_is(5'h08);
    step(10'h200, 4'h0, 13'h020);
  endtask
  // A reset in mid-run must drop a fault state straight back to power off.
  task automatic t_reset();
    step(10'h100, 4'h1, 13'h001);
    step(10'h011, 4'h2, 13'h040);
    @(negedge clk);
    rst <= 1'b1;
    @(negedge clk);
    rst <= 1'b0;
    look(4'h0, 13'h000);
    tx_is(5'h10);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst <= 1'b0;
    t_power();
    t_faults();
    t_merge();
    t_recover();
    t_reset();
    end_of_test();
  end
endmodule
bind ntfsm_top ntfsm_monitor i_mon (.*);
